// ---- logic/sir_core.sv ----
// interrupt generation and reset handling for a scsi bus controller
// assumes host strobes are on sys_clk_i; scsi and dma pins arrive async
module sir_core
   import sir_pkg::*;
#(
   parameter int EOP_CYC = EOP_MIN_CYC,
   parameter int BSY_CYC = BUS_SETTLE_CYC
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // host register port
   input wire logic host_cs_i,
   input wire logic host_rd_i,
   input wire logic host_wr_i,
   input wire logic [2:0] host_addr_i,
   input wire logic [7:0] host_data_i,
   output logic [7:0] host_data_o,
   output logic host_data_oe_o,
   // scsi bus
   input wire sir_lines_s scsi_lines_i,
   input wire logic scsi_atn_i,
   input wire logic scsi_ack_i,
   input wire logic [7:0] scsi_data_i,
   output logic [7:0] scsi_data_o,
   output logic scsi_dbp_o,
   output logic scsi_data_oe_o,
   output logic scsi_rst_o,
   output logic scsi_rst_oe_o,
   // dma controller
   input wire sir_dma_s dma_pins_i,
   output logic dma_ready_o,
   // interrupt
   output logic irq_o,
   output logic resel_o
);

   localparam int EW = $clog2(EOP_CYC + 1);
   localparam int BW = $clog2(BSY_CYC + 1);
   localparam logic [EW-1:0] EOP_LAST = EW'(EOP_CYC - 1);
   localparam logic [EW-1:0] EOP_SAT = EW'(EOP_CYC);
   localparam logic [BW-1:0] BSY_LAST = BW'(BSY_CYC - 1);
   localparam logic [BW-1:0] BSY_SAT = BW'(BSY_CYC);

   if (EOP_CYC < 1 || BSY_CYC < 1) begin : g_chk
      $error("sir_core: EOP_CYC and BSY_CYC must be at least 1");
   end

   // synchronised pins
   sir_pins_s pins;
   sir_lines_s ln;

   sir_sync3 #(
      .W($bits(sir_pins_s))
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i({scsi_lines_i, scsi_atn_i, scsi_ack_i, scsi_data_i, dma_pins_i}),
      .sync_o(pins)
   );

   assign ln = pins.lines;

   // registers
   logic [7:0] mode;
   logic [7:0] initiator_command_reg;
   logic [3:0] target_phase_control;
   logic [7:0] select_enable_mask;
   logic [7:0] out_data;
   logic [7:0] in_data;

   // status flags
   logic parity_err;
   logic busy_err;
   logic dma_done;
   logic irq;
   logic phase_halt;
   logic block_stall;
   logic resel;

   // edge history and width counters
   logic rd_q;
   logic wr_q;
   logic req_q;
   logic ack_q;
   logic sel_q;
   logic [EW-1:0] eop_cnt;
   logic [BW-1:0] bsy_cnt;

   // decoded events
   logic rd_p;
   logic wr_p;
   logic bus_rst;
   logic dma_on;
   logic phase_ok;
   logic req_rise;
   logic ack_rise;
   logic id_match;
   logic sel_cond;
   logic sel_evt;
   logic recv_evt;
   logic recv_dir;
   logic mismatch_evt;
   logic par_chk;
   logic par_set;
   logic eop_all;
   logic eop_hit;
   logic bsy_watch;
   logic busy_hit;
   logic clr7;
   logic irq_set;
   logic [7:0] bus_stat;
   logic [7:0] next_rd_data;

   // side effects fire once per strobe, however long the host holds it
   assign rd_p = host_cs_i & host_rd_i & ~rd_q;
   assign wr_p = host_cs_i & host_wr_i & ~wr_q;
   assign clr7 = rd_p & (host_addr_i == ADDR_IRQ_CLEAR);

   // own assert-reset comes back as a bus reset, so both act alike
   assign bus_rst = ln.rst | initiator_command_reg[ICR_ASSERT_RST_BIT];

   assign dma_on = mode[MODE_DMA_BIT];
   assign phase_ok = (target_phase_control[TCR_MSG_BIT] == ln.msg) && (target_phase_control[TCR_CD_BIT] == ln.cd)
      && (target_phase_control[TCR_IO_BIT] == ln.io);
   assign req_rise = ln.req & ~req_q;
   assign ack_rise = pins.ack & ~ack_q;
   assign mismatch_evt = dma_on & req_rise & ~phase_ok;

   // a zero mask can never match, which disables (re)selection
   assign id_match = |(select_enable_mask & pins.data);
   assign sel_cond = ln.sel & ~ln.bsy & id_match;
   assign sel_evt = sel_cond & ~sel_q;

   // receive byte strobe: target latches on ack, initiator on req
   assign recv_dir = mode[MODE_TARGET_BIT] ? ~target_phase_control[TCR_IO_BIT] : ln.io;
   assign recv_evt = dma_on & recv_dir & (mode[MODE_TARGET_BIT] ? ack_rise : req_rise);

   // odd parity over data and parity line
   assign par_chk = mode[MODE_PAR_CHK_BIT]
      & ((rd_p & (host_addr_i == ADDR_CUR_DATA)) | sel_evt | recv_evt);
   assign par_set = par_chk & ~(^{pins.data, ln.data_bus_parity_line});

   assign eop_all = pins.dma.eop & pins.dma.dma_grant & (pins.dma.io_read_strobe | pins.dma.io_write_strobe);
   assign eop_hit = dma_on & eop_all & (eop_cnt == EOP_LAST);

   assign bsy_watch = mode[MODE_BSY_MON_BIT] & ~ln.bsy;
   assign busy_hit = bsy_watch & (bsy_cnt == BSY_LAST);

   assign irq_set = (par_set & mode[MODE_PAR_IRQ_BIT])
      | (eop_hit & mode[MODE_EOP_IRQ_BIT])
      | mismatch_evt
      | busy_hit
      | sel_evt
      | bus_rst;

   // strobe and line history
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         req_q <= 1'b0;
         ack_q <= 1'b0;
         sel_q <= 1'b0;
      end else begin
         rd_q <= host_cs_i & host_rd_i;
         wr_q <= host_cs_i & host_wr_i;
         req_q <= ln.req;
         ack_q <= pins.ack;
         sel_q <= sel_cond;
      end
   end

   // minimum-width counters, saturating so each fires once per episode
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || bus_rst) begin
         eop_cnt <= '0;
         bsy_cnt <= '0;
      end else begin
         if (!eop_all) begin
            eop_cnt <= '0;
         end else if (eop_cnt != EOP_SAT) begin
            eop_cnt <= eop_cnt + EW'(1);
         end
         if (!bsy_watch) begin
            bsy_cnt <= '0;
         end else if (bsy_cnt != BSY_SAT) begin
            bsy_cnt <= bsy_cnt + BW'(1);
         end
      end
   end

   // mode register; target bit survives a bus reset
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         mode <= MODE_RST;
      end else if (bus_rst) begin
         mode <= mode & MODE_KEEP_MASK;
      end else if (wr_p && host_addr_i == ADDR_MODE) begin
         mode <= host_data_i;
      end
   end

   // initiator command; assert-reset stays writable so it can be released
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         initiator_command_reg <= ICR_RST;
      end else if (bus_rst) begin
         initiator_command_reg <= {(wr_p && host_addr_i == ADDR_INIT_CMD) ? host_data_i[7]
                 : initiator_command_reg[ICR_ASSERT_RST_BIT], 7'h00};
      end else if (wr_p && host_addr_i == ADDR_INIT_CMD) begin
         initiator_command_reg <= host_data_i;
      end
   end

   // phase, select mask and data registers
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || bus_rst) begin
         target_phase_control <= TCR_RST;
         select_enable_mask <= SER_RST;
         out_data <= DATA_RST;
         in_data <= DATA_RST;
      end else begin
         if (wr_p && host_addr_i == ADDR_TGT_PHASE) begin
            target_phase_control <= host_data_i[3:0];
         end
         if (wr_p && host_addr_i == ADDR_SEL_MASK) begin
            select_enable_mask <= host_data_i;
         end
         if (wr_p && host_addr_i == ADDR_CUR_DATA) begin
            out_data <= host_data_i;
         end
         if (recv_evt) begin
            in_data <= pins.data;
         end
      end
   end

   // sticky status; a set in the clearing cycle wins
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         parity_err <= 1'b0;
         busy_err <= 1'b0;
         dma_done <= 1'b0;
         irq <= 1'b0;
         resel <= 1'b0;
      end else if (bus_rst) begin
         parity_err <= 1'b0;
         busy_err <= 1'b0;
         dma_done <= 1'b0;
         irq <= 1'b1;
         resel <= 1'b0;
      end else begin
         parity_err <= par_set | (parity_err & ~clr7);
         busy_err <= busy_hit | (busy_err & ~clr7);
         dma_done <= eop_hit | (dma_done & dma_on);
         irq <= irq_set | (irq & ~clr7);
         if (sel_evt) begin
            resel <= ln.io;
         end else if (clr7) begin
            resel <= 1'b0;
         end
      end
   end

   // dma halt latches, released when software drops the dma mode bit
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || bus_rst) begin
         phase_halt <= 1'b0;
         block_stall <= 1'b0;
      end else begin
         phase_halt <= mismatch_evt | (phase_halt & dma_on);
         block_stall <= mismatch_evt | (eop_hit & recv_dir)
            | (block_stall & dma_on);
      end
   end

   // host read path
   assign bus_stat = {dma_done, 1'b0, parity_err, irq, phase_ok, busy_err,
                      pins.atn, pins.ack};

   always_comb begin
      case (host_addr_i)
         ADDR_CUR_DATA: next_rd_data = pins.data;
         ADDR_INIT_CMD: next_rd_data = initiator_command_reg;
         ADDR_MODE: next_rd_data = mode;
         ADDR_TGT_PHASE: next_rd_data = {4'h0, target_phase_control};
         ADDR_LINE_STAT: next_rd_data = ln;
         ADDR_BUS_STAT: next_rd_data = bus_stat;
         ADDR_IN_DATA: next_rd_data = in_data;
         default: next_rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         host_data_o <= 8'h00;
      end else if (host_cs_i && host_rd_i) begin
         host_data_o <= next_rd_data;
      end
   end

   assign host_data_oe_o = host_cs_i & host_rd_i;

   // pin drive; chip reset clears the command bit, so it never drives bus reset
   assign scsi_data_o = out_data;
   assign scsi_dbp_o = ~(^out_data);
   assign scsi_data_oe_o = initiator_command_reg[ICR_DATA_DRV_BIT] & ~phase_halt;
   assign scsi_rst_o = initiator_command_reg[ICR_ASSERT_RST_BIT];
   assign scsi_rst_oe_o = initiator_command_reg[ICR_ASSERT_RST_BIT];
   // in block mode an error leaves ready low; outside glue must recover
   assign dma_ready_o = mode[MODE_BLOCK_BIT] & dma_on & pins.dma.dma_grant & ~block_stall;
   assign irq_o = irq;
   assign resel_o = resel;

   // checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   AST_IRQ_CLEAR: assert property (
      clr7 && !irq_set |=> !irq_o)
      else $error("interrupt not cleared by read at address 7");

   AST_IRQ_HOLD: assert property (
      irq_o && !clr7 |=> irq_o)
      else $error("interrupt dropped without a clearing read");

   AST_PAR_FLAG: assert property (
      par_set && !bus_rst |=> parity_err)
      else $error("parity error flag not set");

   AST_PAR_MASK: assert property (
      !irq_o && par_set && !mode[MODE_PAR_IRQ_BIT] && !eop_hit && !mismatch_evt
      && !busy_hit && !sel_evt && !bus_rst |=> !irq_o)
      else $error("parity error raised a masked interrupt");

   AST_EOP_WIDTH: assert property (
      $rose(dma_done) |-> $past(eop_all) && $past(eop_cnt) == EOP_LAST)
      else $error("end of transfer accepted before minimum width");

   AST_EOP_IRQ: assert property (
      eop_hit && mode[MODE_EOP_IRQ_BIT] && !bus_rst |=> irq_o && dma_done)
      else $error("end of transfer did not interrupt");

   AST_MISMATCH: assert property (
      mismatch_evt && !bus_rst |=> irq_o && phase_halt && !scsi_data_oe_o)
      else $error("phase mismatch did not interrupt and halt");

   AST_DATA_OFF: assert property (
      phase_halt |-> !scsi_data_oe_o)
      else $error("data bus driven after phase mismatch");

   AST_BUSY_LOSS: assert property (
      $rose(busy_err) |-> $past(bsy_watch) && $past(bsy_cnt) == BSY_LAST)
      else $error("busy loss flagged before settle time");

   AST_SEL_MASK: assert property (
      sel_evt |-> select_enable_mask != 8'h00 && ln.sel && !ln.bsy)
      else $error("selection event with empty mask or bad lines");

   AST_BUS_RST: assert property (
      bus_rst |=> irq_o && (mode & ~MODE_KEEP_MASK) == 8'h00)
      else $error("bus reset did not clear and interrupt");

   AST_CHIP_RST: assert property (
      disable iff (1'b0) sys_rst_i |=> !irq_o && !scsi_rst_oe_o && mode == MODE_RST)
      else $error("chip reset left state or interrupt behind");

endmodule : sir_core

// ---- logic/sir_pkg.sv ----
// constants, field positions and pin bundles for the scsi interrupt/reset block
// assumes a single 250 MHz clock and a synchronous active-high chip reset
package sir_pkg;

   // clock and timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int EOP_MIN_NS = 40;
   localparam int EOP_MIN_CYC = (EOP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUS_SETTLE_NS = 400;
   localparam int BUS_SETTLE_CYC = (BUS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // register addresses
   localparam logic [2:0] ADDR_CUR_DATA = 3'h0;
   localparam logic [2:0] ADDR_INIT_CMD = 3'h1;
   localparam logic [2:0] ADDR_MODE = 3'h2;
   localparam logic [2:0] ADDR_TGT_PHASE = 3'h3;
   localparam logic [2:0] ADDR_LINE_STAT = 3'h4;
   localparam logic [2:0] ADDR_SEL_MASK = 3'h4;
   localparam logic [2:0] ADDR_BUS_STAT = 3'h5;
   localparam logic [2:0] ADDR_IN_DATA = 3'h6;
   localparam logic [2:0] ADDR_IRQ_CLEAR = 3'h7;

   // mode_control_reg fields
   localparam int MODE_DMA_BIT = 1;
   localparam int MODE_BSY_MON_BIT = 2;
   localparam int MODE_EOP_IRQ_BIT = 3;
   localparam int MODE_PAR_IRQ_BIT = 4;
   localparam int MODE_PAR_CHK_BIT = 5;
   localparam int MODE_TARGET_BIT = 6;
   localparam int MODE_BLOCK_BIT = 7;

   // initiator_command_reg fields
   localparam int ICR_DATA_DRV_BIT = 0;
   localparam int ICR_ASSERT_RST_BIT = 7;

   // target_phase_control fields
   localparam int TCR_IO_BIT = 0;
   localparam int TCR_CD_BIT = 1;
   localparam int TCR_MSG_BIT = 2;

   // reset values and bits kept across a bus reset
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] ICR_RST = 8'h00;
   localparam logic [3:0] TCR_RST = 4'h0;
   localparam logic [7:0] SER_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] MODE_KEEP_MASK = 8'h40;

   // scsi control lines, in scsi_line_status bit order (7 down to 0)
   typedef struct packed {
      logic rst;
      logic bsy;
      logic req;
      logic msg;
      logic cd;
      logic io;
      logic sel;
      logic data_bus_parity_line;
   } sir_lines_s;

   // dma strobes from the dma controller
   typedef struct packed {
      logic eop;
      logic dma_grant;
      logic io_read_strobe;
      logic io_write_strobe;
   } sir_dma_s;

   // everything that arrives asynchronously from pins
   typedef struct packed {
      sir_lines_s lines;
      logic atn;
      logic ack;
      logic [7:0] data;
      sir_dma_s dma;
   } sir_pins_s;

endpackage : sir_pkg

// ---- logic/sir_sync3.sv ----
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to sys_clk_i; output lags a change by 4 edges
module sir_sync3 #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // pins in, filtered levels out
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   if (W < 1) begin : g_chk
      $error("sir_sync3: W must be at least 1");
   end

   for (genvar i = 0; i < W; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;

      // s1 feeds s2 only; the filter looks at s2 and s3
      always_ff @(posedge sys_clk_i) begin
         if (sys_rst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            sync_o[i] <= 1'b0;
         end else begin
            s1 <= async_i[i];
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
               sync_o[i] <= s3;
            end
         end
      end
   end

endmodule : sir_sync3

// ---- test/sir_far_model.sv ----
// far side of the block: scsi bus peers, dma controller and its glue
// assumes the bench calls its tasks just after a rising clock edge
module sir_far_model
   import sir_pkg::*;
(
   // status from the device
   input wire logic irq_i,
   input wire logic ready_i,
   // lines towards the device
   output sir_lines_s lines_o,
   output logic atn_o,
   output logic ack_o,
   output logic [7:0] data_o,
   output sir_dma_s dma_o
);
   timeunit 1ns;
   timeprecision 100ps;
   sir_lines_s lines = '0;
   sir_dma_s dma_q = '0;
   logic [7:0] data_q = 8'h00;
   logic drv = 1'b0;
   logic atn_q = 1'b0;
   logic ack_q = 1'b0;
   assign lines_o = lines;
   assign atn_o = atn_q;
   assign ack_o = ack_q;
   // released bus shows the inverse, never a stale copy
   assign data_o = drv ? data_q : ~data_q;
   // glue ends a stalled block cycle instead of hanging the bus
   assign dma_o = dma_q | {dma_q.dma_grant & irq_i & ~ready_i, 3'h0};
   task automatic set_lines(input sir_lines_s l);
      lines = l;
   endtask : set_lines
   task automatic put_data(input logic [7:0] d);
      data_q = d;
      drv = 1'b1;
   endtask : put_data
   task automatic free_data();
      drv = 1'b0;
   endtask : free_data
   task automatic set_dma(input sir_dma_s d);
      dma_q = d;
   endtask : set_dma
   task automatic set_ctl(input logic a, input logic c);
      atn_q = a;
      ack_q = c;
   endtask : set_ctl
endmodule : sir_far_model

// ---- test/scsi_interrupt_reset_logic_bench.sv ----
// self-checking bench for sir_core with the far-side model
// assumes host strobes on the core clock and pins sampled through its synchroniser
module scsi_interrupt_reset_logic_bench;
   import sir_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {logic [7:0] val; logic [7:0] mask;} sir_note_s;
   logic sys_clk_i, sys_rst_i, cs, rd_s, wr_s, host_oe, scsi_oe, rst_o, rst_oe, ready, irq, resel;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, sdata_o, sdata, d;
   logic dbp_o, atn, ack;
   sir_lines_s lines;
   sir_dma_s dma;
   sir_note_s notes[$];
   sir_note_s note;
   int err_count = 0;
   int comparisons = 0;
   int id, k;

   sir_core #(.EOP_CYC(4), .BSY_CYC(8)) DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .host_cs_i(cs), .host_rd_i(rd_s), .host_wr_i(wr_s), .host_addr_i(addr),
      .host_data_i(wdata), .host_data_o(rdata), .host_data_oe_o(host_oe),
      .scsi_lines_i(lines), .scsi_atn_i(atn), .scsi_ack_i(ack), .scsi_data_i(sdata),
      .scsi_data_o(sdata_o), .scsi_dbp_o(dbp_o), .scsi_data_oe_o(scsi_oe), .scsi_rst_o(rst_o),
      .scsi_rst_oe_o(rst_oe), .dma_pins_i(dma), .dma_ready_o(ready), .irq_o(irq),
      .resel_o(resel));
   sir_far_model FAR (.irq_i(irq), .ready_i(ready), .lines_o(lines), .atn_o(atn),
      .ack_o(ack), .data_o(sdata), .dma_o(dma));

   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : idle

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge sys_clk_i);
      #1 {cs, wr_s, addr, wdata} = {2'b11, a, v};
      idle(1);
      {cs, wr_s} = 2'b00;
   endtask : wr

   task automatic rd(input logic [2:0] a, input logic [7:0] v, input logic [7:0] m);
      notes.push_back('{val: v, mask: m});
      @(posedge sys_clk_i);
      #1 {cs, rd_s, addr} = {2'b11, a};
      idle(1);
      chk({7'h00, host_oe}, 8'h01);
      {cs, rd_s} = 2'b00;
   endtask : rd

   task automatic wait_irq(input int n);
      for (int i = 0; i < n && irq !== 1'b1; i++) idle(1);
      chk({7'h00, irq}, 8'h01);
      if (irq !== 1'b1) stop_test();
   endtask : wait_irq

   task automatic clear();
      rd(ADDR_IRQ_CLEAR, 8'h00, 8'hFF);
      idle(1);
      chk({7'h00, irq}, 8'h00);
   endtask : clear

   // read results land on the same edge that takes the strobe
   always @(posedge sys_clk_i) begin
      if (cs === 1'b1 && rd_s === 1'b1) begin
         #2;
         if (notes.size() == 0) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=none", $time, rdata);
         end else begin
            note = notes.pop_front();
            chk(rdata & note.mask, note.val & note.mask);
         end
      end
   end

   initial begin
      {cs, rd_s, wr_s, addr, wdata, sys_rst_i} = {3'b000, 3'h0, 8'h00, 1'b1};
      id = $urandom(65409);
      idle(5);
      sys_rst_i = 1'b0;
      rd(ADDR_MODE, 8'h00, 8'hFF);
      rd(ADDR_BUS_STAT, 8'h00, 8'hF4);
      chk({6'h00, irq, rst_oe}, 8'h00);
      $display("test reset finished");

      id = $urandom_range(7, 0);
      wr(ADDR_SEL_MASK, 8'h01 << id);
      for (k = 0; k < 2; k++) begin
         FAR.put_data(8'h01 << id);
         FAR.set_lines('{sel: 1'b1, io: k[0], default: 1'b0});
         wait_irq(40);
         chk({7'h00, resel}, {7'h00, k[0]});
         rd(ADDR_LINE_STAT, {5'h00, k[0], 2'b10}, 8'hFF);
         FAR.set_lines('0);
         FAR.free_data();
         clear();
      end
      for (k = 0; k < 2; k++) begin
         if (k == 1) wr(ADDR_SEL_MASK, 8'h00);
         FAR.put_data(k == 0 ? 8'h01 << ((id + 1) % 8) : 8'hFF);
         FAR.set_lines('{sel: 1'b1, default: 1'b0});
         idle(30);
         chk({7'h00, irq}, 8'h00);
         FAR.set_lines('0);
         FAR.free_data();
      end
      $display("test selection finished");

      wr(ADDR_MODE, 8'h0A);
      FAR.set_dma('{eop: 1'b1, dma_grant: 1'b1, default: 1'b0});
      idle(30);
      chk({7'h00, irq}, 8'h00);
      FAR.set_dma('{eop: 1'b1, dma_grant: 1'b1, io_read_strobe: 1'b1, io_write_strobe: 1'b0});
      wait_irq(40);
      FAR.set_dma('0);
      rd(ADDR_BUS_STAT, 8'h80, 8'h80);
      clear();
      wr(ADDR_MODE, 8'h00);
      wr(ADDR_MODE, 8'h02);
      FAR.set_dma('{eop: 1'b1, dma_grant: 1'b1, io_write_strobe: 1'b1, io_read_strobe: 1'b0});
      idle(30);
      chk({7'h00, irq}, 8'h00);
      FAR.set_dma('0);
      rd(ADDR_BUS_STAT, 8'h80, 8'h80);
      wr(ADDR_MODE, 8'h00);
      $display("test end of dma finished");

      wr(ADDR_TGT_PHASE, 8'h02);
      wr(ADDR_INIT_CMD, 8'h01);
      FAR.set_dma('{dma_grant: 1'b1, default: 1'b0});
      wr(ADDR_MODE, 8'h82);
      for (k = 0; k < 2; k++) begin
         if (k == 1) wr(ADDR_TGT_PHASE, 8'h00);
         idle(10);
         chk({6'h00, scsi_oe, ready}, 8'h03);
         FAR.set_lines('{req: 1'b1, cd: 1'b1, msg: k[0], default: 1'b0});
         if (k == 0) idle(30);
         else wait_irq(40);
         chk({4'h0, dma.eop, irq, scsi_oe, ready}, k == 0 ? 8'h03 : 8'h0C);
         if (k == 0) FAR.set_lines('0);
      end
      rd(ADDR_BUS_STAT, 8'h00, 8'h08);
      rd(ADDR_LINE_STAT, 8'h38, 8'hFF);
      FAR.set_lines('0);
      FAR.set_dma('0);
      clear();
      wr(ADDR_MODE, 8'h00);
      wr(ADDR_INIT_CMD, 8'h00);
      $display("test phase mismatch finished");

      FAR.set_lines('{bsy: 1'b1, default: 1'b0});
      wr(ADDR_MODE, 8'h04);
      idle(10);
      FAR.set_lines('0);
      idle(4);
      FAR.set_lines('{bsy: 1'b1, default: 1'b0});
      idle(30);
      chk({7'h00, irq}, 8'h00);
      FAR.set_lines('0);
      wait_irq(40);
      rd(ADDR_BUS_STAT, 8'h04, 8'h04);
      wr(ADDR_MODE, 8'h00);
      clear();
      $display("test busy loss finished");

      d = 8'($urandom);
      wr(ADDR_CUR_DATA, d);
      chk(sdata_o, d);
      chk({7'h00, dbp_o}, {7'h00, ~^d});
      FAR.put_data(d);
      FAR.set_lines('{data_bus_parity_line: ^d, default: 1'b0});
      for (k = 0; k < 2; k++) begin
         wr(ADDR_MODE, k == 0 ? 8'h30 : 8'h20);
         idle(6);
         rd(ADDR_CUR_DATA, d, 8'hFF);
         idle(20);
         chk({7'h00, irq}, k == 0 ? 8'h01 : 8'h00);
         rd(ADDR_BUS_STAT, 8'h20, 8'h20);
         rd(ADDR_IRQ_CLEAR, 8'h00, 8'hFF);
      end
      FAR.set_lines('{data_bus_parity_line: ~^d, default: 1'b0});
      idle(6);
      rd(ADDR_CUR_DATA, d, 8'hFF);
      rd(ADDR_BUS_STAT, 8'h00, 8'h20);
      // target dma receive latches the byte on the ack edge
      wr(ADDR_MODE, 8'h62);
      FAR.set_ctl(1'b1, 1'b1);
      idle(8);
      rd(ADDR_IN_DATA, d, 8'hFF);
      rd(ADDR_BUS_STAT, 8'h03, 8'h23);
      FAR.set_ctl(1'b0, 1'b0);
      wr(ADDR_MODE, 8'h30);
      wr(ADDR_SEL_MASK, 8'hFF);
      FAR.put_data(8'h81);
      FAR.set_lines('{sel: 1'b1, data_bus_parity_line: 1'b0, default: 1'b0});
      wait_irq(40);
      rd(ADDR_BUS_STAT, 8'h20, 8'h20);
      FAR.set_lines('0);
      FAR.free_data();
      clear();
      $display("test parity finished");

      wr(ADDR_MODE, 8'h46);
      FAR.set_lines('{rst: 1'b1, default: 1'b0});
      idle(10);
      FAR.set_lines('0);
      idle(8);
      rd(ADDR_MODE, 8'h40, 8'hFF);
      chk({7'h00, irq}, 8'h01);
      clear();
      wr(ADDR_MODE, 8'h46);
      wr(ADDR_INIT_CMD, 8'h80);
      idle(8);
      chk({6'h00, rst_o, rst_oe}, 8'h03);
      rd(ADDR_MODE, 8'h40, 8'hFF);
      chk({7'h00, irq}, 8'h01);
      wr(ADDR_INIT_CMD, 8'h00);
      chk({7'h00, rst_oe}, 8'h00);
      clear();
      wr(ADDR_INIT_CMD, 8'h80);
      sys_rst_i = 1'b1;
      idle(1);
      sys_rst_i = 1'b0;
      chk({6'h00, irq, rst_oe}, 8'h00);
      rd(ADDR_MODE, 8'h00, 8'hFF);
      idle(2);
      $display("test resets finished");
      stop_test();
   end

   initial begin
      #200000;
      err_count++;
      stop_test();
   end
endmodule : scsi_interrupt_reset_logic_bench
